// ---- dv/asep_host_sva.sv ----
// asep_host_sva: pin and handshake checks for asep_host
// assumes it is bound into asep_host and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module asep_host_sva
  import asep_pkg::*;
#(
  parameter int RD_CYCLES = RD_CYC,
  parameter int WE_CYCLES = WE_CYC,
  parameter int WR_CYCLES = WR_CYC
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // request side
  input wire logic              wordMode,
  input wire logic              reqValid,
  input wire asep_req_s         req,
  input wire logic              reqReady,
  input wire logic              rspValid,
  // memory pins
  input wire asep_pins_s        pins,
  input wire logic [DATA_W-1:0] dataOe
);
  localparam int RD_LAT = RD_CYCLES + 4;
  localparam int WR_LAT = WR_CYCLES + 1;
  localparam int WE_LEN = WE_CYCLES;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    reqValid && reqReady && (!wordMode || req.lowerLane || req.upperLane);
  endsequence
  sequence s_take_rd;
    s_take ##0 !req.write;
  endsequence
  sequence s_take_wr;
    s_take ##0 req.write;
  endsequence
  a_read_answer: assert property (s_take_rd |-> ##RD_LAT rspValid ##1 !rspValid)
    else $error("read answer late or not one cycle");
  a_write_answer: assert property (s_take_wr |-> ##WR_LAT (rspValid && reqReady))
    else $error("write answer at wrong cycle");
  a_write_start_all: assert property ($fell(pins.writeN) |-> !pins.selectLowN && pins.selectHigh
    && (!wordMode || !pins.lowerLaneN || !pins.upperLaneN) && dataOe != '0)
    else $error("write strobe without selects, lane or data");
  a_write_end_all: assert property ($rose(pins.writeN) |-> pins.selectLowN && !pins.selectHigh
    && pins.lowerLaneN && pins.upperLaneN)
    else $error("write controls not released together");
  a_write_pulse_len: assert property ($fell(pins.writeN) |-> ##WE_LEN $rose(pins.writeN))
    else $error("write strobe width wrong");
  a_no_contention: assert property (!pins.outGateN |-> dataOe == '0)
    else $error("host drives data while memory outputs on");
  a_byte_upper_quiet: assert property (!wordMode |-> dataOe[15:8] == 8'h00
    && (pins.selectLowN || (pins.lowerLaneN && pins.upperLaneN)))
    else $error("byte mode uses upper pins or lanes");
  a_idle_deselect: assert property (reqReady |-> pins.selectLowN && !pins.selectHigh && pins.writeN)
    else $error("memory selected while host idle");
endmodule
bind asep_host asep_host_sva #(.RD_CYCLES(RD_CYCLES), .WE_CYCLES(WE_CYCLES), .WR_CYCLES(WR_CYCLES)) u_sva (
  .clk(clk), .sys_rst(sys_rst), .wordMode(wordMode), .reqValid(reqValid), .req(req),
  .reqReady(reqReady), .rspValid(rspValid), .pins(pins), .dataOe(dataOe));
`default_nettype wire

// ---- dv/asep_mem_model.sv ----
// asep_mem_model: behavioural static memory with lanes, width strap and error flag
// assumes asep_host pins; reads of badAddr report a corrected error
`timescale 1ns/1ps
`default_nettype none
module asep_mem_model
  import asep_pkg::*;
(
  // host pins
  input  wire asep_pins_s        pins,
  input  wire logic [DATA_W-1:0] dataOut,
  input  wire logic [DATA_W-1:0] dataOe,
  output var  logic [DATA_W-1:0] dataIn,
  output wire logic              errIn,
  // strap and fault control
  input  wire logic              wordMode,
  input  wire logic [ADDR_W-1:0] badAddr
);
  logic [7:0]  mem [logic [22:0]];
  logic        sel, lo, hi, rd, wr, cl, ch;
  logic [15:0] drv, memQ, wd;
  logic [15:0] lastQ = '0;
  logic [22:0] kLo, kHi, cLo, cHi;
  assign sel = !pins.selectLowN && pins.selectHigh;
  assign lo = wordMode ? !pins.lowerLaneN : 1'b1;
  assign hi = wordMode && !pins.upperLaneN;
  assign rd = sel && pins.writeN && !pins.outGateN && (lo || hi);
  assign wr = sel && !pins.writeN && (lo || hi);
  assign kLo = {wordMode, pins.addr, 1'b0};
  assign kHi = {wordMode, pins.addr, 1'b1};
  assign drv = rd ? {{8{hi}}, {8{lo}}} : '0;
  assign errIn = rd ? (pins.addr == badAddr) : 1'bz;
  // released lines show the inverse of the last driven value
  always @* begin
    memQ = {mem.exists(kHi) ? mem[kHi] : 8'h00, mem.exists(kLo) ? mem[kLo] : 8'h00};
    for (int i = 0; i < 16; i++) begin
      dataIn[i] = dataOe[i] ? dataOut[i] : (drv[i] ? memQ[i] : ~lastQ[i]);
    end
  end
  always @* if (rd) lastQ = memQ;
  always @* begin
    if (wr) begin
      cLo = kLo;
      cHi = kHi;
      cl = lo;
      ch = hi;
      wd = dataIn;
    end
  end
  // store when the first control leaves the overlap
  always @(negedge wr) begin
    if (cl) mem[cLo] = wd[7:0];
    if (ch) mem[cHi] = wd[15:8];
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// tb_top: directed tests of asep_host against a behavioural memory
// assumes default timing parameters of asep_host
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb_top
  import asep_pkg::*;
;
  logic              clk = 0, sys_rst = 1, wordMode = 1, reqValid = 0;
  logic              reqReady, rspValid, rspCorrected, errIn, corr;
  asep_req_s         req = '0;
  asep_pins_s        pins;
  logic [DATA_W-1:0] rspData, dataIn, dataOut, dataOe, rdq;
  logic [ADDR_W-1:0] badAddr = '1;
  int                num_errors = 0, total_checks = 0, cyc = 0;
  asep_host DUT (.clk(clk), .sys_rst(sys_rst), .wordMode(wordMode), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspCorrected(rspCorrected),
    .pins(pins), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .errIn(errIn));
  asep_mem_model mem (.pins(pins), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
    .errIn(errIn), .wordMode(wordMode), .badAddr(badAddr));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one access launched at a falling edge once the host is ready
  task automatic acc(input logic w, lo, hi, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    reqValid = 1;
    req = '{w, lo, hi, a, d};
    @(negedge clk);
    reqValid = 0;
    n = 0;
    while (rspValid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    // counted from the falling edge after acceptance, so one less than the answer edge
    `CHK(n, (w ? WR_CYC + 1 : RD_CYC + 4) - 1)
    rdq = rspData;
    corr = rspCorrected;
  endtask
  task automatic t_word();
    acc(1, 1, 1, 21'h00123, 16'ha55a);
    acc(0, 1, 1, 21'h00123, 16'h0000);
    `CHK(rdq, 16'ha55a)
    `CHK(corr, 1'b0)
    $display("t_word done");
  endtask
  task automatic t_lanes();
    acc(1, 1, 1, 21'h00456, 16'h1234);
    acc(1, 1, 0, 21'h00456, 16'hffab);
    acc(1, 0, 1, 21'h00456, 16'hcdff);
    acc(0, 1, 1, 21'h00456, 16'h0000);
    `CHK(rdq, 16'hcdab)
    acc(0, 1, 0, 21'h00456, 16'h0000);
    `CHK(rdq, 16'h00ab)
    acc(0, 0, 1, 21'h00456, 16'h0000);
    `CHK(rdq, 16'hcd00)
    $display("t_lanes done");
  endtask
  task automatic t_byte();
    wordMode = 0;
    acc(1, 0, 0, 21'h1abcd, 16'h77e1);
    acc(0, 0, 0, 21'h1abcd, 16'h0000);
    `CHK(rdq, 16'h00e1)
    wordMode = 1;
    $display("t_byte done");
  endtask
  task automatic t_err();
    badAddr = 21'h00123;
    acc(0, 1, 1, 21'h00123, 16'h0000);
    `CHK({corr, rdq}, {1'b1, 16'ha55a})
    acc(1, 1, 1, 21'h00123, 16'h0f0f);
    `CHK(corr, 1'b0)
    badAddr = '1;
    $display("t_err done");
  endtask
  task automatic t_nolane();
    reqValid = 1;
    req = '{1'b1, 1'b0, 1'b0, 21'h00123, 16'hffff};
    repeat (6) @(negedge clk);
    `CHK({reqReady, pins.writeN, dataOe}, {2'h3, 16'h0000})
    reqValid = 0;
    @(negedge clk);
    acc(0, 1, 1, 21'h00123, 16'h0000);
    `CHK(rdq, 16'h0f0f)
    $display("t_nolane done");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 0;
    `CHK({reqReady, rspValid, pins.selectLowN, pins.selectHigh, pins.writeN}, 5'h15)
    t_word();
    t_lanes();
    t_byte();
    t_err();
    t_nolane();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- logic/asep_host.sv ----
// asep_host: host controller driving an asynchronous static memory with
// byte lanes, width strap and error flag
// assumes memory pins are sampled through synchronisers; one request at a time
`timescale 1ns/1ps
`default_nettype none
module asep_host
  import asep_pkg::*;
#(
  parameter int RD_CYCLES   = RD_CYC,
  parameter int WE_CYCLES   = WE_CYC,
  parameter int WR_CYCLES   = WR_CYC,
  parameter int TURN_CYCLES = TURN_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // configuration
  input  wire logic              wordMode,
  // request side
  input  wire logic              reqValid,
  input  wire asep_req_s         req,
  output var  logic              reqReady,
  output var  logic              rspValid,
  output var  logic [DATA_W-1:0] rspData,
  output var  logic              rspCorrected,
  // memory pins
  output var  asep_pins_s        pins,
  input  wire logic [DATA_W-1:0] dataIn,
  output var  logic [DATA_W-1:0] dataOut,
  output var  logic [DATA_W-1:0] dataOe,
  input  wire logic              errIn
);
  // refuse cycle counts that the counter or the sequencing cannot serve
  if (RD_CYCLES < 1 || WE_CYCLES < 1 || WR_CYCLES <= WE_CYCLES || TURN_CYCLES < 1 ||
      RD_CYCLES + RD_SYNC_EXTRA >= 2**CNT_W || WR_CYCLES >= 2**CNT_W) begin : g_bad_cycles
    $error("asep_host: cycle counts out of range");
  end

  localparam logic [CNT_W-1:0] RD_END   = CNT_W'(RD_CYCLES + RD_SYNC_EXTRA);
  localparam logic [CNT_W-1:0] WE_END   = CNT_W'(WE_CYCLES);
  localparam logic [CNT_W-1:0] WR_END   = CNT_W'(WR_CYCLES);
  localparam logic [CNT_W-1:0] TURN_END = CNT_W'(TURN_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  // synchronised memory outputs: read data and error flag
  logic [DATA_W:0] syncIn;
  asep_sync #(.W(DATA_W + 1)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({errIn, dataIn}),
    .syncOut (syncIn)
  );

  // idle pin pattern: deselected and lanes off
  function automatic asep_pins_s idlePins(input logic [ADDR_W-1:0] a);
    asep_pins_s p;
    p.selectLowN = 1'b1;
    p.selectHigh = 1'b0;
    p.writeN     = 1'b1;
    p.outGateN   = 1'b1;
    p.upperLaneN = 1'b1;
    p.lowerLaneN = 1'b1;
    p.addr       = a;
    return p;
  endfunction

  // data enables for a write given mode and lanes
  function automatic logic [DATA_W-1:0] laneOe(input logic wm, input logic lo, input logic up);
    logic [DATA_W-1:0] m;
    m = '0;
    if (!wm) begin
      m[BYTE_W-1:0] = '1;
    end else begin
      if (lo) m[BYTE_W-1:0] = '1;
      if (up) m[DATA_W-1:BYTE_W] = '1;
    end
    return m;
  endfunction

  asep_state_e       state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  asep_pins_s        pins_q, pins_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic [DATA_W-1:0] doe_q, doe_d;
  logic              ready_q, ready_d;
  logic              rspV_q, rspV_d;
  logic [DATA_W-1:0] rspD_q, rspD_d;
  logic              rspE_q, rspE_d;
  logic              wm_q, wm_d;
  logic              lo_q, lo_d;
  logic              up_q, up_d;
  logic              useLow, useUp;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    pins_d  = pins_q;
    dout_d  = dout_q;
    doe_d   = doe_q;
    ready_d = ready_q;
    rspV_d  = 1'b0;
    rspD_d  = rspD_q;
    rspE_d  = rspE_q;
    wm_d    = wm_q;
    lo_d    = lo_q;
    up_d    = up_q;
    useLow  = req.lowerLane;
    useUp   = req.upperLane;
    case (state_q)
      ST_IDLE: begin
        if (reqValid && ready_q && (!wordMode || useLow || useUp)) begin
          ready_d = 1'b0;
          cnt_d   = '0;
          wm_d    = wordMode;
          lo_d    = wordMode ? useLow : 1'b1;
          up_d    = wordMode ? useUp : 1'b0;
          pins_d.addr       = req.addr;
          pins_d.selectLowN = 1'b0;
          pins_d.selectHigh = 1'b1;
          pins_d.lowerLaneN = wordMode ? !useLow : 1'b1;
          pins_d.upperLaneN = wordMode ? !useUp : 1'b1;
          if (req.write) begin
            // strobe, selects and lanes asserted in one edge
            pins_d.writeN   = 1'b0;
            pins_d.outGateN = 1'b1;
            dout_d = wordMode ? req.wdata : {BYTE_ZERO, req.wdata[BYTE_W-1:0]};
            doe_d  = laneOe(wordMode, useLow, useUp);
            state_d = ST_WRITE;
          end else begin
            pins_d.writeN   = 1'b1;
            pins_d.outGateN = 1'b0;
            doe_d   = '0;
            state_d = ST_READ;
          end
        end
      end
      ST_READ: begin
        cnt_d = cnt_q + CNT_ONE;
        if (cnt_q == RD_END) begin
          rspV_d = 1'b1;
          rspD_d = '0;
          if (!wm_q) begin
            rspD_d[BYTE_W-1:0] = syncIn[BYTE_W-1:0];
          end else begin
            if (lo_q) rspD_d[BYTE_W-1:0] = syncIn[BYTE_W-1:0];
            if (up_q) rspD_d[DATA_W-1:BYTE_W] = syncIn[DATA_W-1:BYTE_W];
          end
          rspE_d  = syncIn[DATA_W];
          pins_d  = idlePins(pins_q.addr);
          cnt_d   = '0;
          state_d = ST_TURN;
        end
      end
      ST_WRITE: begin
        cnt_d = cnt_q + CNT_ONE;
        if (cnt_q + CNT_ONE == WE_END) begin
          // all controls drop together; data held one more edge
          pins_d  = idlePins(pins_q.addr);
          state_d = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        cnt_d = cnt_q + CNT_ONE;
        doe_d = '0;
        if (cnt_q + CNT_ONE >= WR_END) begin
          rspV_d  = 1'b1;
          rspE_d  = 1'b0;
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_TURN: begin
        // memory output must reach high impedance before host drives
        cnt_d = cnt_q + CNT_ONE;
        if (cnt_q + CNT_ONE >= TURN_END) begin
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        pins_d  = idlePins('0);
        doe_d   = '0;
        ready_d = 1'b1;
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      pins_q  <= idlePins('0);
      dout_q  <= '0;
      doe_q   <= '0;
      ready_q <= 1'b1;
      rspV_q  <= 1'b0;
      rspD_q  <= '0;
      rspE_q  <= 1'b0;
      wm_q    <= 1'b1;
      lo_q    <= 1'b0;
      up_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pins_q  <= pins_d;
      dout_q  <= dout_d;
      doe_q   <= doe_d;
      ready_q <= ready_d;
      rspV_q  <= rspV_d;
      rspD_q  <= rspD_d;
      rspE_q  <= rspE_d;
      wm_q    <= wm_d;
      lo_q    <= lo_d;
      up_q    <= up_d;
    end
  end

  assign pins         = pins_q;
  assign dataOut      = dout_q;
  assign dataOe       = doe_q;
  assign reqReady     = ready_q;
  assign rspValid     = rspV_q;
  assign rspData      = rspD_q;
  assign rspCorrected = rspE_q;
endmodule
`default_nettype wire

// ---- logic/asep_pkg.sv ----
// asep_pkg: constants and carrier types for the static memory host port
// assumes a 100 MHz host clock and an asynchronous memory on the pins
`default_nettype none
package asep_pkg;
  localparam int CLK_MHZ    = 100;
  localparam int CLK_PER_NS = 1000 / CLK_MHZ;

  // pin timing figures in ns (slow speed grade)
  localparam int T_RC_NS    = 55;
  localparam int T_WC_NS    = 55;
  localparam int T_PWE_NS   = 40;
  localparam int T_SD_NS    = 25;
  localparam int T_HZWE_NS  = 20;
  localparam int T_HZOE_NS  = 18;

  // least times round up to whole cycles
  localparam int RD_CYC   = (T_RC_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int WE_CYC   = ((T_PWE_NS > T_HZWE_NS + T_SD_NS ? T_PWE_NS : T_HZWE_NS + T_SD_NS)
                             + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int WR_CYC   = ((T_WC_NS > T_PWE_NS ? T_WC_NS : T_PWE_NS) + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int TURN_CYC = (T_HZOE_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  // extra read cycles so the data has passed the two synchroniser flops
  localparam int RD_SYNC_EXTRA = 2;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 8;

  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic              write;
    logic              lowerLane;
    logic              upperLane;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asep_req_s;

  typedef struct packed {
    logic              selectLowN;
    logic              selectHigh;
    logic              writeN;
    logic              outGateN;
    logic              upperLaneN;
    logic              lowerLaneN;
    logic [ADDR_W-1:0] addr;
  } asep_pins_s;

  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WRITE, ST_RECOVER, ST_TURN} asep_state_e;
endpackage
`default_nettype wire

// ---- logic/asep_sync.sv ----
// asep_sync: two-flop synchroniser for a vector of pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module asep_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] asyncIn,
  output var  logic [W-1:0] syncOut
);
  logic [W-1:0] stage1_q;
  logic [W-1:0] stage1_d;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage2_d;

  always_comb begin
    stage1_d = asyncIn;
    stage2_d = stage1_q;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign syncOut = stage2_q;
endmodule
`default_nettype wire
